/* inc/breath_pkg.sv */
// Constants, register map and state types of the breathing pattern controller.
// Assumes a byte-wide register port fed by the chip's serial host interface.
//
// Contract
// RL1: Engine runs only while the engine enable bit is one.
// RL2: Each three-LED group follows the engine when its member bit is set.
// RL3: Mode select one gives an autonomous breathing waveform without host help.
// RL4: A loop is rise, on, fall, off, each timed by its duration field.
// RL5: Breathing peaks at the upper level and bottoms at the lower level.
// RL6: The loop starts at the period chosen by the loop begin field.
// RL7: Nonzero stop field ends loops after rise; zero ends them after fall.
// RL8: Repeat count is twelve bits over two registers; zero repeats forever.
// RL9: Finished repetitions set the done flag; reading the run register clears it.
// RL10: Restarting, or writing mode select zero, also clears the done flag.
// RL11: Writing one to the run bit starts the autonomous pattern.
// RL12: Host sets levels, groups, timing, enable, mode and ramp, then run.
// RL13: Manual mode outputs upper level when choice bit is one, else lower.
// RL14: With ramp on, level choice changes ramp smoothly to the new level.
// RL15: With ramp off, level choice changes switch the output at once.
// RL16: Twelve member bits select groups; disabled engine feeds groups the lower level.
// RL17: Shared colour off bit picks shared colours or each channel's own colour.
// RL18: Duration codes map through a table; levels step on internal ticks.
// RL19: Registers reset to zero; clearing enable halts pattern and clears done.
package breath_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_PATTERN_CONFIGURATION   = 8'hA0;
  localparam logic [7:0] ADDR_PATTERN_RUN_CONTROL     = 8'hA1;
  localparam logic [7:0] ADDR_RISE_ON_DURATIONS       = 8'hA2;
  localparam logic [7:0] ADDR_FALL_OFF_DURATIONS      = 8'hA3;
  localparam logic [7:0] ADDR_LOOP_POINTS_REPEAT_HIGH = 8'hA4;
  localparam logic [7:0] ADDR_REPEAT_COUNT_LOW        = 8'hA5;
  localparam logic [7:0] ADDR_UPPER_LEVEL             = 8'hA6;
  localparam logic [7:0] ADDR_LOWER_LEVEL             = 8'hA7;
  localparam logic [7:0] ADDR_SHARED_RED_LEVEL        = 8'hA8;
  localparam logic [7:0] ADDR_SHARED_GREEN_LEVEL      = 8'hA9;
  localparam logic [7:0] ADDR_SHARED_BLUE_LEVEL       = 8'hAA;
  localparam logic [7:0] ADDR_GROUP_SELECT_LOW        = 8'hAB;
  localparam logic [7:0] ADDR_GROUP_SELECT_HIGH       = 8'hAC;

  // Field positions
  localparam int ENGINE_ENABLE_BIT     = 0;
  localparam int MODE_SELECT_BIT       = 1;
  localparam int SMOOTH_TRANSITION_BIT = 2;
  localparam int LEVEL_CHOICE_BIT      = 3;
  localparam int RUN_BIT               = 0;
  localparam int RUN_STATUS_BIT        = 1;
  localparam int DONE_FLAG_BIT         = 2;
  localparam int SHARED_COLOR_OFF_BIT  = 4;

  // Writable masks and reset value
  localparam logic [7:0] CONFIG_MASK     = 8'h0F;
  localparam logic [7:0] SELECT_HI_MASK  = 8'h1F;
  localparam logic [7:0] REG_RESET_VALUE = 8'h00;

  // Step tick: levels move one count per tick
  localparam int CLOCK_PERIOD_NS = 50;
  localparam int STEP_TIME_NS    = 1_000_000;
  localparam int STEP_CYCLES     = STEP_TIME_NS / CLOCK_PERIOD_NS;

  // Duration code to step ticks
  localparam logic [15:0] DURATION_TABLE [16] = '{
    16'h0000, 16'h0080, 16'h0100, 16'h0180, 16'h0200, 16'h0300, 16'h0400, 16'h0600,
    16'h0800, 16'h0A00, 16'h0C00, 16'h1000, 16'h1400, 16'h1800, 16'h1C00, 16'h2000};

  typedef enum logic [1:0] {phase_rise, phase_on, phase_fall, phase_off} phase_t;

  typedef struct packed {
    logic [7:0]        pattern_configuration;
    logic [7:0]        rise_on_durations;
    logic [7:0]        fall_off_durations;
    logic [7:0]        loop_points_repeat_high;
    logic [7:0]        repeat_count_low;
    logic [7:0]        upper_level;
    logic [7:0]        lower_level;
    logic [7:0]        shared_red_level;
    logic [7:0]        shared_green_level;
    logic [7:0]        shared_blue_level;
    logic [7:0]        group_select_low;
    logic [7:0]        group_select_high;
    logic              running;
    logic              done_flag;
    phase_t            phase;
    logic [15:0]       phase_cnt;
    logic [14:0]       tick_cnt;
    logic              tick;
    logic [11:0]       loop_cnt;
    logic [7:0]        level;
    logic [7:0]        rd_data;
    logic [35:0]       engine_ctl;
    logic [35:0][7:0]  br_out;
    logic [35:0][7:0]  col_out;
  } state_t;

endpackage : breath_pkg

/* hw/breath_engine.sv */
// Breathing pattern controller with its register bank and per-channel source muxes.
// Assumes the serial host slave presents byte reads and writes as one-cycle strobes.
`timescale 1ns/100ps

module breath_engine
  import breath_pkg::*;
#(
  parameter int STEP_TICK_CYCLES = STEP_CYCLES
)(
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_write,
  input  wire logic              reg_read,
  output logic      [7:0]        reg_rdata,
  input  wire logic [35:0][7:0]  col_in,
  output logic      [35:0]       led_engine_ctl,
  output logic      [35:0][7:0]  led_br,
  output logic      [35:0][7:0]  led_col,
  output logic      [7:0]        engine_level
);

  state_t s;
  state_t next_s;

  // Decoded fields of the current state
  logic        enable;
  logic        auto_mode;
  logic        ramp_on;
  logic        choice;
  logic [1:0]  loop_begin_field;
  logic [1:0]  loop_stop_point;
  logic [11:0] repeat_count;
  logic [11:0] group_member_bit;
  logic [7:0]  manual_target;
  logic [15:0] phase_len;

  assign enable           = s.pattern_configuration[ENGINE_ENABLE_BIT];
  assign auto_mode        = s.pattern_configuration[MODE_SELECT_BIT];
  assign ramp_on          = s.pattern_configuration[SMOOTH_TRANSITION_BIT];
  assign choice           = s.pattern_configuration[LEVEL_CHOICE_BIT];
  assign loop_begin_field = s.loop_points_repeat_high[5:4];
  assign loop_stop_point  = s.loop_points_repeat_high[7:6];
  assign repeat_count     = {s.loop_points_repeat_high[3:0], s.repeat_count_low};
  assign group_member_bit = {s.group_select_high[3:0], s.group_select_low}; // RL16
  assign manual_target    = choice ? s.upper_level : s.lower_level;

  // Duration of the running period, looked up from its code
  always_comb
  begin
    unique case (s.phase)
      phase_rise: phase_len = DURATION_TABLE[s.rise_on_durations[7:4]];  // RL18
      phase_on:   phase_len = DURATION_TABLE[s.rise_on_durations[3:0]];
      phase_fall: phase_len = DURATION_TABLE[s.fall_off_durations[7:4]];
      phase_off:  phase_len = DURATION_TABLE[s.fall_off_durations[3:0]];
    endcase
  end

  // Next state: bus, engine, then per-channel sources
  always_comb
  begin
    logic     at_stop;
    logic     period_end;
    logic     restart;
    phase_t   start_phase;
    logic [1:0] color_pos;
    next_s      = s;
    at_stop     = 1'b0;
    period_end  = 1'b0;
    start_phase = phase_t'(loop_begin_field);
    color_pos   = 2'b00;
    // A restart on a tick edge would otherwise be undone by the step
    restart     = reg_write && reg_addr == ADDR_PATTERN_RUN_CONTROL && reg_wdata[RUN_BIT];

    // Free-running step divider
    next_s.tick = (s.tick_cnt == 15'(STEP_TICK_CYCLES - 1));
    next_s.tick_cnt = next_s.tick ? 15'h0000 : 15'(s.tick_cnt + 15'h0001);

    // Register reads; reading the run register drops the done flag
    if (reg_read)
    begin
      unique case (reg_addr)
        ADDR_PATTERN_CONFIGURATION:   next_s.rd_data = s.pattern_configuration;
        ADDR_PATTERN_RUN_CONTROL:
        begin
          next_s.rd_data = {5'h00, s.done_flag, s.running, s.running};
          next_s.done_flag = 1'b0;  // RL9
        end
        ADDR_RISE_ON_DURATIONS:       next_s.rd_data = s.rise_on_durations;
        ADDR_FALL_OFF_DURATIONS:      next_s.rd_data = s.fall_off_durations;
        ADDR_LOOP_POINTS_REPEAT_HIGH: next_s.rd_data = s.loop_points_repeat_high;
        ADDR_REPEAT_COUNT_LOW:        next_s.rd_data = s.repeat_count_low;
        ADDR_UPPER_LEVEL:             next_s.rd_data = s.upper_level;
        ADDR_LOWER_LEVEL:             next_s.rd_data = s.lower_level;
        ADDR_SHARED_RED_LEVEL:        next_s.rd_data = s.shared_red_level;
        ADDR_SHARED_GREEN_LEVEL:      next_s.rd_data = s.shared_green_level;
        ADDR_SHARED_BLUE_LEVEL:       next_s.rd_data = s.shared_blue_level;
        ADDR_GROUP_SELECT_LOW:        next_s.rd_data = s.group_select_low;
        ADDR_GROUP_SELECT_HIGH:       next_s.rd_data = s.group_select_high;
        default:                      next_s.rd_data = 8'h00;
      endcase
    end

    // Register writes
    if (reg_write)
    begin
      unique case (reg_addr)
        ADDR_PATTERN_CONFIGURATION:
        begin
          next_s.pattern_configuration = reg_wdata & CONFIG_MASK;
          if (!reg_wdata[MODE_SELECT_BIT])
            next_s.done_flag = 1'b0;  // RL10
        end
        ADDR_PATTERN_RUN_CONTROL:
        begin
          if (reg_wdata[RUN_BIT])
          begin
            // Restart from the chosen period
            next_s.running   = 1'b1;  // RL11
            next_s.done_flag = 1'b0;  // RL10
            next_s.phase     = start_phase;  // RL6
            next_s.phase_cnt = 16'h0000;
            next_s.loop_cnt  = 12'h000;
            next_s.level     = (start_phase == phase_on || start_phase == phase_fall)
                               ? s.upper_level : s.lower_level;
          end
        end
        ADDR_RISE_ON_DURATIONS:       next_s.rise_on_durations = reg_wdata;
        ADDR_FALL_OFF_DURATIONS:      next_s.fall_off_durations = reg_wdata;
        ADDR_LOOP_POINTS_REPEAT_HIGH: next_s.loop_points_repeat_high = reg_wdata;
        ADDR_REPEAT_COUNT_LOW:        next_s.repeat_count_low = reg_wdata;
        ADDR_UPPER_LEVEL:             next_s.upper_level = reg_wdata;
        ADDR_LOWER_LEVEL:             next_s.lower_level = reg_wdata;
        ADDR_SHARED_RED_LEVEL:        next_s.shared_red_level = reg_wdata;
        ADDR_SHARED_GREEN_LEVEL:      next_s.shared_green_level = reg_wdata;
        ADDR_SHARED_BLUE_LEVEL:       next_s.shared_blue_level = reg_wdata;
        ADDR_GROUP_SELECT_LOW:        next_s.group_select_low = reg_wdata;
        ADDR_GROUP_SELECT_HIGH:       next_s.group_select_high = reg_wdata & SELECT_HI_MASK;
        default:                      ;
      endcase
    end

    // Engine; completion is applied after the read and mode-write clears so that it wins
    if (!enable)
    begin
      next_s.running   = 1'b0;  // RL19
      next_s.done_flag = 1'b0;  // RL19
      next_s.level     = s.lower_level;  // RL1
    end
    else if (auto_mode)
    begin
      if (s.running && s.tick && !restart)  // RL11
      begin
        period_end = (s.phase_cnt + 16'h0001 >= phase_len);  // RL4
        next_s.phase_cnt = s.phase_cnt + 16'h0001;
        // One count per tick toward the period's target
        if (s.phase == phase_rise && s.level < s.upper_level)
          next_s.level = s.level + 8'h01;  // RL18
        if (s.phase == phase_fall && s.level > s.lower_level)
          next_s.level = s.level - 8'h01;  // RL18
        if (period_end)
        begin
          // Snap to the period's end level
          if (s.phase == phase_rise || s.phase == phase_on)
            next_s.level = s.upper_level;  // RL5
          else
            next_s.level = s.lower_level;  // RL5
          at_stop = (loop_stop_point != 2'b00) ? (s.phase == phase_rise)
                                               : (s.phase == phase_fall);  // RL7
          next_s.phase     = phase_t'(2'(s.phase + 2'b01));  // RL3
          next_s.phase_cnt = 16'h0000;
          if (at_stop)
          begin
            next_s.loop_cnt = s.loop_cnt + 12'h001;  // RL7
            if (repeat_count != 12'h000 && s.loop_cnt + 12'h001 == repeat_count)
            begin
              next_s.running   = 1'b0;  // RL8
              next_s.done_flag = 1'b1;  // RL9
            end
          end
        end
      end
    end
    else if (ramp_on)
    begin
      // Manual ramp walks toward the chosen level
      if (s.tick && s.level < manual_target)
        next_s.level = s.level + 8'h01;  // RL14
      else if (s.tick && s.level > manual_target)
        next_s.level = s.level - 8'h01;  // RL14
    end
    else
    begin
      next_s.level = manual_target;  // RL13 RL15
    end

    // Per-channel brightness and colour sources
    for (int i = 0; i < 36; i++)
    begin
      color_pos = 2'(i % 3);
      next_s.engine_ctl[i] = group_member_bit[i / 3];  // RL2
      if (group_member_bit[i / 3])
      begin
        next_s.br_out[i] = enable ? s.level : s.lower_level;  // RL16
        if (s.group_select_high[SHARED_COLOR_OFF_BIT])
          next_s.col_out[i] = col_in[i];  // RL17
        else if (color_pos == 2'd0)
          next_s.col_out[i] = s.shared_red_level;  // RL17
        else if (color_pos == 2'd1)
          next_s.col_out[i] = s.shared_green_level;
        else
          next_s.col_out[i] = s.shared_blue_level;
      end
      else
      begin
        next_s.br_out[i]  = 8'h00;
        next_s.col_out[i] = col_in[i];
      end
    end
  end

  // State register; everything clears on reset
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      s <= '0;  // RL19
    else
      s <= next_s;
  end

  assign reg_rdata      = s.rd_data;
  assign led_engine_ctl = s.engine_ctl;
  assign led_br         = s.br_out;
  assign led_col        = s.col_out;
  assign engine_level   = s.level;

  // Checks
  sequence run_write_s;
    reg_write && reg_addr == ADDR_PATTERN_RUN_CONTROL && reg_wdata[RUN_BIT];
  endsequence

  sequence manual_direct_s;
    enable && !auto_mode && !ramp_on && !reg_write;
  endsequence

  sequence rise_end_s;
    enable && auto_mode && s.running && s.tick && s.phase == phase_rise
      && s.phase_cnt + 16'h0001 >= phase_len && !reg_write;
  endsequence

  sequence period_end_s;
    enable && auto_mode && s.running && s.tick
      && s.phase_cnt + 16'h0001 >= phase_len && !reg_write;
  endsequence

  sequence fall_end_s;
    period_end_s ##0 (s.phase == phase_fall);
  endsequence

  engine_off_halts_a: assert property (@(posedge clock) disable iff (rst) // RL1
    !enable && !reg_write |=> !s.running && !s.done_flag && s.level == $past(s.lower_level))
    else $error("disabled engine still running");

  group_follows_a: assert property (@(posedge clock) disable iff (rst) // RL2
    s.group_select_low[0] && !reg_write |=> ##1 led_engine_ctl[2:0] == 3'b111)
    else $error("group member bit not honoured");

  run_start_point_a: assert property (@(posedge clock) disable iff (rst) // RL6
    run_write_s ##0 enable |=> s.running && s.phase == phase_t'($past(loop_begin_field)))
    else $error("loop did not start at chosen period");

  rise_peak_a: assert property (@(posedge clock) disable iff (rst) // RL5
    rise_end_s |=> s.level == $past(s.upper_level) && s.phase == phase_on)
    else $error("rise did not end at upper level");

  stop_point_a: assert property (@(posedge clock) disable iff (rst) // RL7
    rise_end_s ##0 (loop_stop_point != 2'b00)
      |=> s.loop_cnt == $past(s.loop_cnt) + 12'h001)
    else $error("loop counter missed stop at end of rise");

  done_on_finish_a: assert property (@(posedge clock) disable iff (rst) // RL8
    rise_end_s ##0 (loop_stop_point != 2'b00) ##0 (repeat_count != 12'h000)
      ##0 (s.loop_cnt + 12'h001 == repeat_count) |=> !s.running && s.done_flag)
    else $error("done flag not raised on last repetition");

  read_clears_done_a: assert property (@(posedge clock) disable iff (rst) // RL9
    reg_read && reg_addr == ADDR_PATTERN_RUN_CONTROL && !(enable && auto_mode && s.running)
      |=> !s.done_flag)
    else $error("reading run register left done flag set");

  restart_clears_a: assert property (@(posedge clock) disable iff (rst) // RL10
    run_write_s |=> !s.done_flag)
    else $error("restart kept done flag");

  manual_switch_a: assert property (@(posedge clock) disable iff (rst) // RL15
    manual_direct_s ##1 manual_direct_s |-> s.level == $past(manual_target))
    else $error("manual output not switched at once");

  ramp_step_a: assert property (@(posedge clock) disable iff (rst) // RL14
    enable && !auto_mode && ramp_on && !reg_write && s.tick && s.level < manual_target
      |=> s.level == $past(s.level) + 8'h01)
    else $error("manual ramp did not step up");

  level_hold_a: assert property (@(posedge clock) disable iff (rst) // RL18
    enable && auto_mode && s.running && !s.tick && !reg_write |=> $stable(s.level))
    else $error("level moved without a step tick");

  phase_advance_a: assert property (@(posedge clock) disable iff (rst) // RL4
    period_end_s |=> s.phase == phase_t'(2'($past(s.phase) + 2'b01))
      && s.phase_cnt == 16'h0000)
    else $error("period end did not move to the next period");

  fall_floor_a: assert property (@(posedge clock) disable iff (rst) // RL5
    fall_end_s |=> s.level == $past(s.lower_level) && s.phase == phase_off)
    else $error("fall did not end at lower level");

  endless_repeat_a: assert property (@(posedge clock) disable iff (rst) // RL8
    period_end_s ##0 (repeat_count == 12'h000) |=> s.running)
    else $error("unlimited pattern stopped");

  mode_write_clears_a: assert property (@(posedge clock) disable iff (rst) // RL10
    reg_write && reg_addr == ADDR_PATTERN_CONFIGURATION && !reg_wdata[MODE_SELECT_BIT]
      && !(auto_mode && s.running && s.tick) |=> !s.done_flag)
    else $error("manual mode write kept done flag");

  ramp_down_a: assert property (@(posedge clock) disable iff (rst) // RL14
    enable && !auto_mode && ramp_on && !reg_write && s.tick && s.level > manual_target
      |=> s.level == $past(s.level) - 8'h01)
    else $error("manual ramp did not step down");

  disabled_level_a: assert property (@(posedge clock) disable iff (rst) // RL16
    !enable && group_member_bit[0] && !reg_write
      |=> ##1 led_br[0] == $past(s.lower_level, 2))
    else $error("disabled engine group not at lower level");

  shared_red_a: assert property (@(posedge clock) disable iff (rst) // RL17
    group_member_bit[0] && !s.group_select_high[SHARED_COLOR_OFF_BIT]
      |=> led_col[0] == $past(s.shared_red_level))
    else $error("shared red level not applied");

endmodule : breath_engine

/* testbench/reg_host.sv */
// Register host model: byte strobes on the block's register port.
// Assumes one clock; everything moves 1 ns after the rising edge.
`timescale 1ns/100ps

module reg_host (
  input  wire logic       clock,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_write,
  output logic            reg_read,
  input  wire logic [7:0] reg_rdata
);
  // Idle port until the first transfer
  initial
  begin
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read  = 1'b0;
  end

  // Strobe held through its taking edge; data scrambled after release
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
  begin
    @(posedge clock) #1;
    reg_addr  = a;
    reg_wdata = d;
    reg_write = 1'b1;
    @(posedge clock) #1;
    reg_write = 1'b0;
    reg_wdata = ~d;
  end
  endtask : wr

  // Read data is taken only once it has been registered
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
  begin
    @(posedge clock) #1;
    reg_addr = a;
    reg_read = 1'b1;
    @(posedge clock) #1;
    reg_read = 1'b0;
    @(posedge clock) #1;
    d = reg_rdata;
  end
  endtask : rd
endmodule : reg_host

/* testbench/led_breathing_pattern_controller_tb.sv */
// Self-checking bench for the breathing pattern controller.
// Assumes breath_pkg and reg_host are compiled first; step tick shortened to 4 clocks.
`timescale 1ns/100ps

module led_breathing_pattern_controller_tb;
  import breath_pkg::*;
  localparam int STEP = 4;
  localparam int LEN  = int'(DURATION_TABLE[1]);
  logic             clock = 1'b0;
  logic             rst = 1'b1;
  logic [7:0]       reg_addr;
  logic [7:0]       reg_wdata;
  logic             reg_write;
  logic             reg_read;
  logic [7:0]       reg_rdata;
  logic [35:0][7:0] col_in = '0;
  logic [35:0]      led_engine_ctl;
  logic [35:0][7:0] led_br;
  logic [35:0][7:0] led_col;
  logic [7:0]       engine_level;
  logic [7:0]       mreg [8'hA0:8'hAC];
  logic [7:0]       rnd = 8'h03;
  logic [7:0]       rv;
  logic [7:0]       hi;
  logic [7:0]       lo;
  int               errors = 0;
  int               check_count = 0;
  int               cyc = 0;
  int               t_start;

  reg_host host (.clock(clock), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
                 .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata));
  breath_engine #(.STEP_TICK_CYCLES(STEP)) dut (.clock(clock), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .col_in(col_in), .led_engine_ctl(led_engine_ctl),
    .led_br(led_br), .led_col(led_col), .engine_level(engine_level));

  always #25 clock = ~clock;

  // Cycle count and level extremes seen during a run
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (engine_level > hi)
      hi <= engine_level;
    if (engine_level < lo)
      lo <= engine_level;
  end

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  task automatic test_done;
  begin
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  end
  endtask : test_done

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
  begin
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  end
  endtask : chk

  task automatic cycles(input int n);
  begin
    repeat (n) @(posedge clock);
    #1;
  end
  endtask : cycles

  // Writes keep the model image; masked fields mirror the writable bits
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
  begin
    host.wr(a, d);
    if (a == 8'hA0)
      mreg[a] = d & CONFIG_MASK;
    else if (a == 8'hAC)
      mreg[a] = d & SELECT_HI_MASK;
    else if (a >= 8'hA2 && a <= 8'hAB)
      mreg[a] = d;
  end
  endtask : wr

  task automatic chk_regs;
  begin
    for (int a = 8'hA0; a <= 8'hAD; a++)
    begin
      host.rd(a[7:0], rv);
      chk(rv, (a == 8'hA1 || a == 8'hAD) ? 8'h00 : mreg[a]);
    end
  end
  endtask : chk_regs

  // Per-channel source selection against the register image
  task automatic chk_leds(input logic [7:0] lvl, input logic en);
    logic [11:0] grp;
    logic        sel;
  begin
    grp = {mreg[8'hAC][3:0], mreg[8'hAB]};
    for (int i = 0; i < 36; i++)
    begin
      sel = grp[i / 3];
      chk({7'h0, led_engine_ctl[i]}, {7'h0, sel});
      chk(led_br[i], sel ? (en ? lvl : mreg[8'hA7]) : 8'h00);
      chk(led_col[i], (sel && !mreg[8'hAC][4]) ? mreg[8'hA8 + i % 3] : col_in[i]);
    end
  end
  endtask : chk_leds

  task automatic wait_level(input logic [7:0] target);
    int n;
  begin
    n = 0;
    while (engine_level !== target && n < 200 * STEP)
    begin
      cycles(1);
      n++;
    end
    chk(engine_level, target);
    if (engine_level !== target)
      test_done;
  end
  endtask : wait_level

  // Host-order setup of one run, then, when poll is set, end time and extremes against the model
  task automatic run_case(input int b, input int s, input logic [11:0] reps, input bit poll);
    int t;
    int p;
    int n;
  begin
    wr(8'hA0, 8'h00);
    wr(8'hA2, 8'h10);
    wr(8'hA3, 8'h10);
    wr(8'hA4, {s[1:0], b[1:0], reps[11:8]});
    wr(8'hA5, reps[7:0]);
    wr(8'hA0, 8'h01);
    wr(8'hA0, 8'h07);
    wr(8'hA1, 8'h01);
    // Extremes start from 00 and FF once the run write has been taken
    hi = 8'h00;
    lo = 8'hFF;
    t_start = cyc;
    p = b;
    t = (p % 2) ? 1 : LEN;
    while (p != ((s != 0) ? 0 : 2))
    begin
      p = (p + 1) % 4;
      t += (p % 2) ? 1 : LEN;
    end
    t = (t + (int'(reps) - 1) * (2 * LEN + 2)) * STEP;
    n = 0;
    rv = 8'h02;
    if (!poll)
      cycles(t + 4 * STEP);
    while (poll && rv[1] && n < 3000)
    begin
      host.rd(8'hA1, rv);
      n++;
    end
    if (poll)
    begin
      chk(rv, 8'h04);
      chk({7'h0, cyc - t_start >= t - STEP && cyc - t_start <= t + 4 * STEP}, 8'h01);
      chk(hi, mreg[8'hA6]);
      chk(lo, mreg[8'hA7]);
      host.rd(8'hA1, rv);
      chk(rv, 8'h00);
      if (n == 3000)
        test_done;
    end
  end
  endtask : run_case

  // Main sequence
  initial
  begin
    foreach (mreg[a])
      mreg[a] = 8'h00;
    cycles(6);
    rst = 1'b0;
    foreach (col_in[i])
    begin
      rnd = lfsr(rnd);
      col_in[i] = rnd;
    end
    chk_regs;
    for (int a = 8'hA0; a <= 8'hAD; a++)
    begin
      rnd = lfsr(rnd);
      if (a != 8'hA1)
        wr(a[7:0], rnd);
    end
    chk_regs;
    $display("register test done");
    wr(8'hA0, 8'h00);
    for (int k = 0; k < 3; k++)
    begin
      rnd = lfsr(rnd);
      wr(8'hAB, (k == 0) ? 8'h01 : rnd);
      wr(8'hAC, (k == 0) ? 8'h00 : {3'h0, k == 2, rnd[3:0]});
      cycles(2);
      chk_leds(8'h00, 1'b0);
    end
    $display("group test done");
    wr(8'hA6, 8'h90);
    wr(8'hA7, 8'h10);
    wr(8'hA0, 8'h09);
    cycles(2);
    chk(engine_level, 8'h90);
    chk_leds(8'h90, 1'b1);
    wr(8'hA0, 8'h01);
    cycles(2);
    chk(engine_level, 8'h10);
    wr(8'hA0, 8'h0D);
    cycles(10 * STEP);
    chk({7'h0, engine_level > 8'h10 && engine_level < 8'h90}, 8'h01);
    wait_level(8'h90);
    wr(8'hA0, 8'h05);
    wait_level(8'h10);
    $display("manual test done");
    for (int b = 0; b < 4; b++)
      run_case(b, b, 12'h001, 1'b1);
    run_case(0, 0, 12'h002, 1'b1);
    run_case(3, 3, 12'h001, 1'b0);
    chk({7'h0, dut.s.done_flag}, 8'h01);
    wr(8'hA1, 8'h01);
    host.rd(8'hA1, rv);
    chk(rv, 8'h03);
    cycles(2 * LEN * STEP);
    chk({7'h0, dut.s.done_flag}, 8'h01);
    wr(8'hA0, 8'h01);
    host.rd(8'hA1, rv);
    chk(rv, 8'h00);
    $display("autonomous test done");
    run_case(0, 0, 12'h000, 1'b0);
    cycles(3 * (2 * LEN + 2) * STEP);
    host.rd(8'hA1, rv);
    chk(rv, 8'h03);
    wr(8'hA0, 8'h06);
    host.rd(8'hA1, rv);
    chk(rv, 8'h00);
    wr(8'hA1, 8'h01);
    cycles(2);
    host.rd(8'hA1, rv);
    chk(rv, 8'h00);
    chk_leds(8'h00, 1'b0);
    $display("endless and disable test done");
    test_done;
  end
endmodule : led_breathing_pattern_controller_tb
